// >>> rtl/tile_jtag_params.svh
// Purpose: constants of the tile test and debug port
// Assumes: included by the design files by bare name
// Notes: instruction codes, field positions, widths
`ifndef TILE_JTAG_PARAMS_SVH
`define TILE_JTAG_PARAMS_SVH

// Instruction register
`define IR_W 4
`define INS_EXTEST 4'h0
`define INS_SAMPLE 4'h1
`define INS_DEVICE_IDENTITY_WORD 4'h2
`define INS_USERCODE 4'h3
`define INS_ACCESS 4'h8
`define INS_BYPASS 4'hf
`define IR_CAPTURE 4'h1

// Security register fields
`define SEC_JTAG_OFF 0
`define SEC_BOOT_OTP 5
`define SEC_UID_LSB 22
`define SEC_UID_MSB 31
`define UID_W 10
`define USER_UNUSED 6'h00

// Chip access scan word: write, target, address, data
`define ACC_W 51
`define ACC_WR 0
`define ACC_TGT_LSB 1
`define ACC_TGT_MSB 2
`define ACC_ADR_LSB 3
`define ACC_ADR_MSB 18
`define ACC_DAT_LSB 19
`define ACC_DAT_MSB 50

// Boundary register length
`define BSR_PINS 8

`endif

// >>> rtl/tile_jtag_pkg.sv
// Purpose: types of the tile test and debug port
// Assumes: nothing
// Notes: TAP states follow a Gray walk
package tile_jtag_pkg;

	typedef enum logic [3:0] {
		TLR = 4'h0, RTI = 4'h1, SELDR = 4'h3, CAPDR = 4'h2,
		SHDR = 4'h6, EX1DR = 4'h7, PADR = 4'h5, EX2DR = 4'h4,
		UPDR = 4'hc, SELIR = 4'hd, CAPIR = 4'hf, SHIR = 4'he,
		EX1IR = 4'ha, PAIR = 4'hb, EX2IR = 4'h9, UPIR = 4'h8
	} tap_state_t;

	typedef enum logic [1:0] {
		BOOT_HOLD = 2'h0, BOOT_LOCK = 2'h1, BOOT_RUN = 2'h3
	} boot_state_t;

	typedef enum logic [1:0] {
		TGT_TILE = 2'h0, TGT_SWITCH = 2'h1, TGT_OTP = 2'h2
	} acc_target_t;

endpackage : tile_jtag_pkg

// >>> rtl/tap_controller.sv
// Purpose: one TAP: state machine, instruction register, serial out
// Assumes: data registers live in the instantiating module
// Notes: serial out changes on the falling test clock edge
`timescale 1ns/1ps
`include "tile_jtag_params.svh"
module tap_controller
	import tile_jtag_pkg::*;
#(
	parameter int IRW = `IR_W
) (
	input wire logic tck,
	input wire logic trstN,
	input wire logic tms,
	input wire logic tdi,
	input wire logic drSout,
	output logic [IRW-1:0] ir,
	output tap_state_t tapState,
	output logic sout,
	output logic soutEn
);

	tap_state_t stateNxt;
	logic [IRW-1:0] irShift_r;

	always_comb begin
		case (tapState)
			TLR: stateNxt = tms ? TLR : RTI;
			RTI: stateNxt = tms ? SELDR : RTI;
			SELDR: stateNxt = tms ? SELIR : CAPDR;
			CAPDR: stateNxt = tms ? EX1DR : SHDR;
			SHDR: stateNxt = tms ? EX1DR : SHDR;
			EX1DR: stateNxt = tms ? UPDR : PADR;
			PADR: stateNxt = tms ? EX2DR : PADR;
			EX2DR: stateNxt = tms ? UPDR : SHDR;
			UPDR: stateNxt = tms ? SELDR : RTI;
			SELIR: stateNxt = tms ? TLR : CAPIR;
			CAPIR: stateNxt = tms ? EX1IR : SHIR;
			SHIR: stateNxt = tms ? EX1IR : SHIR;
			EX1IR: stateNxt = tms ? UPIR : PAIR;
			PAIR: stateNxt = tms ? EX2IR : PAIR;
			EX2IR: stateNxt = tms ? UPIR : SHIR;
			UPIR: stateNxt = tms ? SELDR : RTI;
			default: stateNxt = TLR;
		endcase
	end

	// Held in reset for as long as the test reset is low
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			tapState <= TLR;
		end else begin
			tapState <= stateNxt;
		end
	end

	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			irShift_r <= '0;
		end else if (tapState == CAPIR) begin
			irShift_r <= IRW'(`IR_CAPTURE);
		end else if (tapState == SHIR) begin
			irShift_r <= {tdi, irShift_r[IRW-1:1]};
		end
	end

	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			ir <= IRW'(`INS_DEVICE_IDENTITY_WORD);
		end else if (tapState == TLR) begin
			ir <= IRW'(`INS_DEVICE_IDENTITY_WORD);
		end else if (tapState == UPIR) begin
			ir <= irShift_r;
		end
	end

	// Output changes on the falling edge
	always_ff @(negedge tck or negedge trstN) begin
		if (!trstN) begin
			sout <= 1'b0;
			soutEn <= 1'b0;
		end else begin
			sout <= (tapState == SHIR) ? irShift_r[0] : drSout;
			soutEn <= (tapState == SHIR) || (tapState == SHDR);
		end
	end

endmodule : tap_controller

// >>> rtl/tile_jtag_debug_port.sv
// Purpose: per-tile test chain, debug sync pin and reset/boot sequencing
// Assumes: tck is the link clock; secReg is static after load
// Notes: chip access crosses to mclk by a toggle handshake
//
// What this block does
// - Two TAPs per tile, chained after reset
// - Boundary-scan TAP scans the I/O pins
// - Chip TAP reaches tile, switch, OTP
// - Test reset low keeps test logic reset
// - Breakpoint drives debug pin low, if enabled
// - Debug pin undriven before a breakpoint
// - Pin pulled low enters debug, if enabled
// - Software sets each tile's pin behaviour
// - DEVICE_IDENTITY_WORD: version, part, maker, one
// - USERCODE: user id, unused, revision
// - User id from security bits 31..22
// - System reset low acts at once
// - Boot only after PLL lock returns
// - JTAG-disable bit refuses tile access
`timescale 1ns/1ps
`include "tile_jtag_params.svh"
module tile_jtag_debug_port
	import tile_jtag_pkg::*;
#(
	parameter int PINS = `BSR_PINS,
	// Identity values are arbitrary
	parameter logic [3:0] ID_VERSION = 4'h1,
	parameter logic [15:0] ID_PART = 16'h0a5c,
	parameter logic [10:0] ID_MAKER = 11'h2b5,
	parameter logic [15:0] SILICON_REV = 16'h0001
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic trstN,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdoEn,
	input wire logic [PINS-1:0] pinIn,
	output logic [PINS-1:0] bsrUpdate,
	output logic extestOn,
	input wire logic [31:0] secReg,
	input wire logic pllLock,
	output logic bootStart,
	output logic bootFromOtp,
	output logic chipRun,
	input wire logic breakpointHit,
	input wire logic dbgOutMode,
	input wire logic dbgInMode,
	input wire logic dbgSyncInN,
	output logic dbgSyncOutN,
	output logic dbgSyncOe,
	output logic debugEnter,
	output logic accReq,
	output logic accWrite,
	output logic [1:0] accTarget,
	output logic [15:0] accAddr,
	output logic [31:0] accWdata,
	input wire logic accAck,
	input wire logic [31:0] accRdata
);

	// Test clock side
	logic [`IR_W-1:0] bsIr;
	logic [`IR_W-1:0] cpIr;
	tap_state_t bsState;
	tap_state_t cpState;
	logic bsSout;
	logic cpSout;
	logic bsDrOut;
	logic cpDrOut;
	logic bsByp_r;
	logic cpByp_r;
	logic [31:0] bsWord_r;
	logic [31:0] cpWord_r;
	logic [PINS-1:0] bsBsr_r;
	logic [PINS-1:0] pinMeta_r;
	logic [PINS-1:0] pinSync_r;
	logic [`UID_W-1:0] uidMeta_r;
	logic [`UID_W-1:0] uidSync_r;
	logic [`ACC_W-1:0] cpAcc_r;
	logic [`ACC_W-1:0] accHold_r;
	logic reqTog_r;
	logic ackMeta_r;
	logic ackSync_r;
	logic pending;

	// System clock side
	logic reqMeta_r;
	logic reqSync_r;
	logic reqSeen_r;
	logic ackTog_r;
	logic accBusy_r;
	logic [31:0] rdataHold_r;
	logic lockMeta_r;
	logic lockSync_r;
	logic dbgMeta_r;
	logic dbgSync_r;
	boot_state_t boot_r;
	boot_state_t bootNxt;

	function automatic logic [31:0] capWord(input logic [`IR_W-1:0] ins,
			input logic [`UID_W-1:0] uid);
		if (ins == `INS_USERCODE) begin
			capWord = {uid, `USER_UNUSED, SILICON_REV};
		end else begin
			capWord = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
		end
	endfunction : capWord

	// Boundary-scan TAP first, chip TAP after it
	tap_controller #(
		.IRW(`IR_W)
	) bscanTap (
		.tck(tck),
		.trstN(trstN),
		.tms(tms),
		.tdi(tdi),
		.drSout(bsDrOut),
		.ir(bsIr),
		.tapState(bsState),
		.sout(bsSout),
		.soutEn()
	);

	tap_controller #(
		.IRW(`IR_W)
	) chipTap (
		.tck(tck),
		.trstN(trstN),
		.tms(tms),
		.tdi(bsSout),
		.drSout(cpDrOut),
		.ir(cpIr),
		.tapState(cpState),
		.sout(cpSout),
		.soutEn(tdoEn)
	);

	assign tdo = cpSout;

	// Pins and security bits into the test clock
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
			uidMeta_r <= '0;
			uidSync_r <= '0;
		end else begin
			pinMeta_r <= pinIn;
			pinSync_r <= pinMeta_r;
			uidMeta_r <= secReg[`SEC_UID_MSB:`SEC_UID_LSB];
			uidSync_r <= uidMeta_r;
		end
	end

	always_comb begin
		case (bsIr)
			`INS_EXTEST, `INS_SAMPLE: bsDrOut = bsBsr_r[0];
			`INS_DEVICE_IDENTITY_WORD, `INS_USERCODE: bsDrOut = bsWord_r[0];
			default: bsDrOut = bsByp_r;
		endcase
	end

	always_comb begin
		case (cpIr)
			`INS_DEVICE_IDENTITY_WORD, `INS_USERCODE: cpDrOut = cpWord_r[0];
			`INS_ACCESS: cpDrOut = cpAcc_r[0];
			default: cpDrOut = cpByp_r;
		endcase
	end

	// Boundary-scan TAP data registers
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			bsByp_r <= 1'b0;
			bsWord_r <= '0;
			bsBsr_r <= '0;
		end else begin
			case (bsState)
				CAPDR: begin
					bsByp_r <= 1'b0;
					bsWord_r <= capWord(bsIr, uidSync_r);
					bsBsr_r <= pinSync_r;
				end
				SHDR: begin
					bsByp_r <= tdi;
					bsWord_r <= {tdi, bsWord_r[31:1]};
					bsBsr_r <= {tdi, bsBsr_r[PINS-1:1]};
				end
				default: begin
					bsByp_r <= bsByp_r;
				end
			endcase
		end
	end

	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			bsrUpdate <= '0;
			extestOn <= 1'b0;
		end else begin
			extestOn <= (bsIr == `INS_EXTEST);
			if (bsState == UPDR && (bsIr == `INS_EXTEST || bsIr == `INS_SAMPLE)) begin
				bsrUpdate <= bsBsr_r;
			end
		end
	end

	// Chip TAP data registers
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			cpByp_r <= 1'b0;
			cpWord_r <= '0;
			cpAcc_r <= '0;
		end else begin
			case (cpState)
				CAPDR: begin
					cpByp_r <= 1'b0;
					cpWord_r <= capWord(cpIr, uidSync_r);
					cpAcc_r <= {rdataHold_r, 18'h00000, ~pending};
				end
				SHDR: begin
					cpByp_r <= bsSout;
					cpWord_r <= {bsSout, cpWord_r[31:1]};
					cpAcc_r <= {bsSout, cpAcc_r[`ACC_W-1:1]};
				end
				default: begin
					cpByp_r <= cpByp_r;
				end
			endcase
		end
	end

	// Access request launch; a second update while busy is dropped
	assign pending = reqTog_r ^ ackSync_r;

	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			reqTog_r <= 1'b0;
			accHold_r <= '0;
		end else if (cpState == UPDR && cpIr == `INS_ACCESS && !pending) begin
			accHold_r <= cpAcc_r;
			reqTog_r <= ~reqTog_r;
		end
	end

	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			ackMeta_r <= 1'b0;
			ackSync_r <= 1'b0;
		end else begin
			ackMeta_r <= ackTog_r;
			ackSync_r <= ackMeta_r;
		end
	end

	// System side of the access handshake
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reqMeta_r <= 1'b0;
			reqSync_r <= 1'b0;
			reqSeen_r <= 1'b0;
		end else begin
			reqMeta_r <= reqTog_r;
			reqSync_r <= reqMeta_r;
			reqSeen_r <= reqSync_r;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			accReq <= 1'b0;
			accBusy_r <= 1'b0;
			accWrite <= 1'b0;
			accTarget <= 2'h0;
			accAddr <= 16'h0000;
			accWdata <= 32'h00000000;
			ackTog_r <= 1'b0;
			rdataHold_r <= 32'h00000000;
		end else begin
			accReq <= 1'b0;
			if (reqSync_r != reqSeen_r) begin
				if (secReg[`SEC_JTAG_OFF]) begin
					rdataHold_r <= 32'h00000000;
					ackTog_r <= ~ackTog_r;
				end else begin
					accReq <= 1'b1;
					accBusy_r <= 1'b1;
					accWrite <= accHold_r[`ACC_WR];
					accTarget <= accHold_r[`ACC_TGT_MSB:`ACC_TGT_LSB];
					accAddr <= accHold_r[`ACC_ADR_MSB:`ACC_ADR_LSB];
					accWdata <= accHold_r[`ACC_DAT_MSB:`ACC_DAT_LSB];
				end
			end else if (accBusy_r && accAck) begin
				accBusy_r <= 1'b0;
				rdataHold_r <= accWrite ? 32'h00000000 : accRdata;
				ackTog_r <= ~ackTog_r;
			end
		end
	end

	// Debug synchronisation pin, open drain
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dbgMeta_r <= 1'b1;
			dbgSync_r <= 1'b1;
		end else begin
			dbgMeta_r <= dbgSyncInN;
			dbgSync_r <= dbgMeta_r;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dbgSyncOutN <= 1'b1;
			dbgSyncOe <= 1'b0;
			debugEnter <= 1'b0;
		end else begin
			dbgSyncOutN <= ~(dbgOutMode & breakpointHit);
			dbgSyncOe <= dbgOutMode & breakpointHit;
			debugEnter <= dbgInMode & ~dbgSync_r;
		end
	end

	// Reset and boot sequencing
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lockMeta_r <= 1'b0;
			lockSync_r <= 1'b0;
		end else begin
			lockMeta_r <= pllLock;
			lockSync_r <= lockMeta_r;
		end
	end

	always_comb begin
		case (boot_r)
			BOOT_HOLD: bootNxt = BOOT_LOCK;
			BOOT_LOCK: bootNxt = lockSync_r ? BOOT_RUN : BOOT_LOCK;
			BOOT_RUN: bootNxt = BOOT_RUN;
			default: bootNxt = BOOT_HOLD;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			boot_r <= BOOT_HOLD;
			bootStart <= 1'b0;
			bootFromOtp <= 1'b0;
			chipRun <= 1'b0;
		end else begin
			boot_r <= bootNxt;
			bootStart <= (boot_r == BOOT_LOCK) && lockSync_r;
			if (boot_r == BOOT_LOCK && lockSync_r) begin
				bootFromOtp <= secReg[`SEC_BOOT_OTP];
				chipRun <= 1'b1;
			end
		end
	end

endmodule : tile_jtag_debug_port

// >>> tb/tile_jtag_debug_port_props.sv
// Purpose: port properties of the tile test and debug port
// Assumes: bound to the top module
// Notes: mclk and tck domains
`timescale 1ns/1ps
module tile_jtag_debug_port_props #(
	parameter int PINS = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic trstN,
	input wire logic tdoEn,
	input wire logic [PINS-1:0] bsrUpdate,
	input wire logic [31:0] secReg,
	input wire logic pllLock,
	input wire logic bootStart,
	input wire logic chipRun,
	input wire logic breakpointHit,
	input wire logic dbgOutMode,
	input wire logic dbgInMode,
	input wire logic dbgSyncInN,
	input wire logic dbgSyncOutN,
	input wire logic dbgSyncOe,
	input wire logic debugEnter,
	input wire logic accReq
);
	sequence s_pin_held;
		(dbgInMode && !dbgSyncInN) [*4];
	endsequence
	sequence s_launch;
		bootStart ##1 (chipRun && !bootStart);
	endsequence
	AST_DBG_DRIVE: assert property (@(posedge mclk) disable iff (!nrst)
		dbgOutMode && breakpointHit |=> dbgSyncOe && !dbgSyncOutN) else $error("pin not driven");
	AST_DBG_LOW: assert property (@(posedge mclk) disable iff (!nrst)
		dbgSyncOe |-> !dbgSyncOutN) else $error("pin driven high");
	AST_DBG_FLOAT: assert property (@(posedge mclk) disable iff (!nrst)
		!(dbgOutMode && breakpointHit) |=> !dbgSyncOe) else $error("pin driven early");
	AST_DBG_ENTER: assert property (@(posedge mclk) disable iff (!nrst)
		s_pin_held |-> debugEnter) else $error("debug not entered");
	AST_DBG_CFG: assert property (@(posedge mclk) disable iff (!nrst)
		!dbgInMode |=> !debugEnter) else $error("debug entered while off");
	AST_BOOT_LOCK: assert property (@(posedge mclk) disable iff (!nrst)
		bootStart |-> $past(pllLock, 3)) else $error("boot before lock");
	AST_BOOT_RUN: assert property (@(posedge mclk) disable iff (!nrst)
		bootStart |-> s_launch) else $error("boot pulse wrong");
	AST_ACC_REFUSE: assert property (@(posedge mclk) disable iff (!nrst)
		secReg[0] |-> !accReq) else $error("access while locked");
	AST_ACC_PULSE: assert property (@(posedge mclk) disable iff (!nrst)
		accReq |=> !accReq) else $error("request too long");
	AST_SYS_RESET: assert property (@(posedge mclk)
		!nrst && $past(nrst) |-> !chipRun && !dbgSyncOe && !accReq) else $error("reset late");
	AST_TEST_RESET: assert property (@(posedge tck)
		!trstN |-> !tdoEn && bsrUpdate == '0) else $error("test logic not reset");
endmodule : tile_jtag_debug_port_props

bind tile_jtag_debug_port tile_jtag_debug_port_props #(.PINS(PINS)) u_props (
	.mclk(mclk), .nrst(nrst), .tck(tck), .trstN(trstN), .tdoEn(tdoEn),
	.bsrUpdate(bsrUpdate), .secReg(secReg), .pllLock(pllLock), .bootStart(bootStart),
	.chipRun(chipRun), .breakpointHit(breakpointHit), .dbgOutMode(dbgOutMode),
	.dbgInMode(dbgInMode), .dbgSyncInN(dbgSyncInN), .dbgSyncOutN(dbgSyncOutN),
	.dbgSyncOe(dbgSyncOe), .debugEnter(debugEnter), .accReq(accReq));

// >>> tb/jtag_probe_model.sv
// Purpose: external debugger on the test chain
// Assumes: tck stands still between scans
// Notes: tdo sampled at each tck rise
`timescale 1ns/1ps
module jtag_probe_model (
	output logic tck,
	output logic trstN,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	logic smp;
	initial begin
		tck = 1'b0;
		trstN = 1'b1;
		tms = 1'b1;
		tdi = 1'b0;
	end
	task automatic step(input logic m, input logic d);
		tms = m;
		tdi = d;
		#3 tck = 1'b1;
		smp = tdo;
		#3 tck = 1'b0;
	endtask : step
	task automatic hold_reset();
		#1 trstN = 1'b0;
		repeat (20) step(1'b1, 1'b0);
		trstN = 1'b1;
		repeat (5) step(1'b1, 1'b0);
	endtask : hold_reset
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		dout = '0;
		repeat (4) step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		if (ir) step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i]);
			dout[i] = smp;
		end
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask : scan
endmodule : jtag_probe_model

// >>> tb/tile_jtag_debug_port_tb_top.sv
// Purpose: self-checking bench of the tile test and debug port
// Assumes: probe model drives the test chain
// Notes: access partner acks every request one cycle later
`timescale 1ns/1ps
module tile_jtag_debug_port_tb_top;
	localparam logic [3:0] IDV = 4'h3;
	localparam logic [15:0] IDP = 16'h1c2d;
	localparam logic [10:0] IDM = 11'h0f1; // arbitrary
	localparam logic [15:0] REV = 16'h0042;
	localparam logic [31:0] RD = 32'h5a3c_96e1;
	logic mclk, nrst, tck, trstN, tms, tdi, tdo, tdoEn, extestOn, pllLock, bootStart;
	logic bootFromOtp, chipRun, breakpointHit, dbgOutMode, dbgInMode, dbgSyncInN;
	logic dbgSyncOutN, dbgSyncOe, debugEnter, accReq, accWrite, accAck, extLow;
	logic [7:0] pinIn, bsrUpdate;
	logic [1:0] accTarget;
	logic [15:0] accAddr;
	logic [31:0] accWdata, accRdata, secReg;
	logic [50:0] seen;
	logic [50:0] w [5];
	logic [63:0] d;
	int reqs = 0, errors = 0, check_count = 0;
	assign dbgSyncInN = !((dbgSyncOe && !dbgSyncOutN) || extLow);
	jtag_probe_model u_probe (.tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi), .tdo(tdo));
	tile_jtag_debug_port #(.ID_VERSION(IDV), .ID_PART(IDP), .ID_MAKER(IDM),
		.SILICON_REV(REV)) i_dut (
		.mclk(mclk), .nrst(nrst), .tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdoEn(tdoEn), .pinIn(pinIn), .bsrUpdate(bsrUpdate),
		.extestOn(extestOn), .secReg(secReg), .pllLock(pllLock), .bootStart(bootStart),
		.bootFromOtp(bootFromOtp), .chipRun(chipRun), .breakpointHit(breakpointHit),
		.dbgOutMode(dbgOutMode), .dbgInMode(dbgInMode), .dbgSyncInN(dbgSyncInN),
		.dbgSyncOutN(dbgSyncOutN), .dbgSyncOe(dbgSyncOe), .debugEnter(debugEnter),
		.accReq(accReq), .accWrite(accWrite), .accTarget(accTarget), .accAddr(accAddr),
		.accWdata(accWdata), .accAck(accAck), .accRdata(accRdata));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		accAck <= accReq;
		if (accReq === 1'b1) begin
			reqs <= reqs + 1;
			seen <= {accWdata, accAddr, accTarget, accWrite};
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5000) @(posedge mclk);
		errors++;
		report_and_stop();
	end
	initial begin
		nrst = 1'b1;
		{pllLock, breakpointHit, dbgOutMode, dbgInMode, extLow} = '0;
		pinIn = 8'ha6;
		accRdata = RD;
		secReg = {10'h2d9, 16'h0000, 6'h20};
		w = '{{32'hc0de_0017, 16'h0123, 2'h0, 1'b1}, {32'h0, 16'h0456, 2'h2, 1'b0},
			{32'h0, 16'h0789, 2'h1, 1'b0}, {32'h0, 16'h0abc, 2'h0, 1'b0}, '0};
		#1 nrst = 1'b0;
		u_probe.hold_reset();
		tick(12);
		nrst = 1'b1;
		tick(20);
		chk(chipRun, 1'b0);
		pllLock = 1'b1;
		for (int i = 0; i < 8 && bootStart !== 1'b1; i++) tick(1);
		chk({bootStart, chipRun, bootFromOtp}, 3'b111);
		tick(1);
		nrst = 1'b0;
		#5 chk({chipRun, dbgSyncOe, accReq}, 3'b000);
		secReg[5] = 1'b0;
		tick(2);
		nrst = 1'b1;
		$display("test boot done");
		dbgOutMode = 1'b1;
		tick(3);
		chk({dbgSyncOe, dbgSyncInN, chipRun, bootFromOtp}, 4'b0110);
		breakpointHit = 1'b1;
		tick(1);
		chk({dbgSyncOe, dbgSyncOutN, dbgSyncInN}, 3'b100);
		dbgOutMode = 1'b0;
		tick(1);
		chk(dbgSyncOe, 1'b0);
		{dbgInMode, extLow, breakpointHit} = 3'b110;
		tick(4);
		chk(debugEnter, 1'b1);
		dbgInMode = 1'b0;
		tick(1);
		chk(debugEnter, 1'b0);
		extLow = 1'b0;
		$display("test debug pin done");
		u_probe.scan(1'b0, 64, 64'h0, d);
		chk(d, {2{IDV, IDP, IDM, 1'b1}});
		u_probe.scan(1'b1, 8, 64'hf3, d);
		chk(d[7:0], 8'h11);
		u_probe.scan(1'b0, 33, 64'h0, d);
		chk(d[31:0], {secReg[31:22], 6'h00, REV});
		$display("test identity done");
		u_probe.scan(1'b1, 8, 64'h1f, d);
		u_probe.scan(1'b0, 9, 64'h78, d);
		chk({d[8:0], bsrUpdate}, {pinIn, 1'b0, 8'h3c});
		u_probe.scan(1'b1, 8, 64'h0f, d);
		repeat (3) u_probe.step(1'b0, 1'b0);
		chk(extestOn, 1'b1);
		$display("test boundary done");
		u_probe.scan(1'b1, 8, 64'hf8, d);
		for (int i = 0; i < 5; i++) begin
			secReg[0] = (i > 2);
			u_probe.scan(1'b0, 52, {13'h0, w[i]}, d);
			if (i > 0) chk(d[50:0], (i == 2 || i == 3) ? {RD, 18'h0, 1'b1} : 51'h1);
			tick(10);
			if (i < 3) chk(i ? seen[18:0] : seen, i ? w[i][18:0] : w[i]);
			else chk(reqs, 3);
		end
		$display("test access done");
		report_and_stop();
	end
endmodule : tile_jtag_debug_port_tb_top
